/* File: shared/mwd_pkg.sv */
package mwd_pkg;

  // ****************************************************************
  // Register map, byte addresses on the APB
  // ****************************************************************
  localparam logic [7:0] ADDR_CONTROL = 8'h4C; // Printed offset 0x13, word index times four.
  localparam logic [7:0] ADDR_CONFIG  = 8'h50; // Printed offset 0x14, word index times four.
  localparam logic [7:0] ADDR_POWER   = 8'h40; // Printed offset 0x10, word index times four.
  localparam logic [7:0] ADDR_STATUS  = 8'h60;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int CTRL_MODE_BIT   = 7;
  localparam int CTRL_ANDOR_BIT  = 6;
  localparam int CFG_CNTEN_BIT   = 3;
  localparam int PWR_PD_LSB      = 4;
  localparam logic [5:0] SLOT_RESET  = 6'h00;
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic [7:0] CFG_RESET   = 8'h00;
  localparam logic [7:0] PWR_RESET   = 8'h00;

  // ****************************************************************
  // Shadow slot codes and sample width
  // ****************************************************************
  localparam logic [2:0] SEL_TH_X  = 3'h1;
  localparam logic [2:0] SEL_CNT_X = 3'h5;
  localparam int SAMPLE_W = 11;
  localparam int NUM_SLOTS = 8;

  // One sample triple from the converter.
  typedef struct packed {
    logic                       valid;
    logic signed [SAMPLE_W-1:0] x;
    logic signed [SAMPLE_W-1:0] y;
    logic signed [SAMPLE_W-1:0] z;
  } mwd_sample_s;

  // Wake status seen by the rest of the sensor.
  typedef struct packed {
    logic       wake;
    logic [2:0] axis_flag;
  } mwd_status_s;

  // Detection state machine.
  typedef enum logic [1:0] {
    MWD_IDLE  = 2'b01,
    MWD_WATCH = 2'b10
  } mwd_state_e;

endpackage

/* File: logic/mwd_slot_mem.sv */
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// Banked 6-bit shadow slots with registered read data
// ****************************************************************
module mwd_slot_mem (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Write port
  input  wire logic       wr_en,
  input  wire logic [2:0] wr_sel,
  input  wire logic [5:0] wr_data,
  // Registered read port
  input  wire logic [2:0] rd_sel,
  output logic      [5:0] rd_data,
  // All slots, flattened, for the detector
  output logic     [47:0] slots
);

  logic [5:0] mem [mwd_pkg::NUM_SLOTS];

  // Slots 0 and 4 map to nothing, so they never store.
  genvar g;
  generate
    for (g = 0; g < mwd_pkg::NUM_SLOTS; g++) begin : g_slot
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mem[g] <= mwd_pkg::SLOT_RESET;
        end else if (wr_en && wr_sel == 3'(g) && (g % 4) != 0) begin
          mem[g] <= wr_data;
        end
      end
      assign slots[g*6 +: 6] = mem[g];
    end
  endgenerate

  // Read data leave through a register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data <= mwd_pkg::SLOT_RESET;
    end else begin
      rd_data <= mem[rd_sel];
    end
  end

endmodule

`default_nettype wire

/* File: logic/mwd_detector.sv */
// Notes on behaviour
// - Selector 010 makes the indirect field reach the Y threshold, 0 to 63.
// - Selector 011 makes the indirect field reach the Z threshold, 0 to 63.
// - Selectors 101, 110, 111 reach the X, Y, Z event counts.
// - Event count holds events minus one; zero means one event suffices.
// - Control bit 6 low: wake when any active axis flags.
// - Control bit 6 high: wake only when all active axes flag together.
// - An axis flags only after threshold exceeded and count met.
// - Power-down bits [6:4] of the power register drop axes from combination.
// - Control bit 7 low: delta is current minus previous sample.
// - Control bit 7 high: delta is current minus stored baseline.
// - Detection event only when delta strictly greater than threshold.
// - Config bits [2:0] pick which shadow slot the field reaches.
// - One enable bit turns on counting; needed for a valid wake.
// - Baseline is the first sample taken on entering detection mode.
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module mwd_detector (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Sensor side
  input  wire logic                 detect_mode,
  input  wire mwd_pkg::mwd_sample_s sample,
  output mwd_pkg::mwd_status_s      status
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [1:0] ctrl_bits;   // Bit 1 is delta method, bit 0 is combine mode.
  logic [7:0] cfg;
  logic [2:0] pd;
  logic [47:0] slots;
  logic [5:0] slot_rd;
  logic       rd_pend;
  logic [7:0] rd_addr;
  mwd_pkg::mwd_state_e state;

  logic setup_wr;
  logic setup_rd;
  logic access;
  logic mapped;
  assign setup_wr = psel && !penable && pwrite;
  assign setup_rd = psel && !penable && !pwrite;
  assign access   = psel && penable;

  function automatic logic addr_mapped(input logic [7:0] a);
    return a == mwd_pkg::ADDR_CONTROL || a == mwd_pkg::ADDR_CONFIG ||
           a == mwd_pkg::ADDR_POWER   || a == mwd_pkg::ADDR_STATUS;
  endfunction

  assign mapped = addr_mapped(paddr);

  // Reads take one wait state so the slot memory can deliver its registered data.
  assign pready  = pwrite ? 1'b1 : rd_pend;
  assign pslverr = access && pready && !mapped;

  // Read pending flag, set after the first access cycle and cleared at the ending access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_pend <= 1'b0;
      rd_addr <= 8'h00;
    end else begin
      // The wait state is the first access cycle of a read; ready follows one cycle later.
      rd_pend <= access && !pwrite && !rd_pend;
      if (setup_rd) begin
        rd_addr <= paddr;
      end
    end
  end

  // Control register: mode bits stored here, the field goes to the slot memory.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_bits <= mwd_pkg::CTRL_RESET[7:6];
    end else if (access && pwrite && paddr == mwd_pkg::ADDR_CONTROL) begin
      ctrl_bits <= {pwdata[mwd_pkg::CTRL_MODE_BIT], pwdata[mwd_pkg::CTRL_ANDOR_BIT]};
    end
  end

  // Configuration and power-down registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= mwd_pkg::CFG_RESET;
      pd  <= mwd_pkg::PWR_RESET[6:4];
    end else if (access && pwrite) begin
      if (paddr == mwd_pkg::ADDR_CONFIG) begin
        cfg <= pwdata[7:0];
      end
      if (paddr == mwd_pkg::ADDR_POWER) begin
        pd <= pwdata[mwd_pkg::PWR_PD_LSB +: 3];
      end
    end
  end

  // ****************************************************************
  // Shadow slots
  // ****************************************************************
  // selector steers field
  mwd_slot_mem u_slots (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (access && pwrite && paddr == mwd_pkg::ADDR_CONTROL),
    .wr_sel  (cfg[2:0]),
    .wr_data (pwdata[5:0]),
    .rd_sel  (cfg[2:0]),
    .rd_data (slot_rd),
    .slots   (slots)
  );

  // ****************************************************************
  // Detection datapath
  // ****************************************************************
  logic signed [mwd_pkg::SAMPLE_W-1:0] cur [3];
  logic signed [mwd_pkg::SAMPLE_W-1:0] prev [3];
  logic signed [mwd_pkg::SAMPLE_W-1:0] base [3];
  logic [5:0] cnt [3];
  logic [2:0] flag;
  logic       first;

  assign cur[0] = sample.x;
  assign cur[1] = sample.y;
  assign cur[2] = sample.z;

  // State: watching only while the sensor is in detection mode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= mwd_pkg::MWD_IDLE;
      first <= 1'b0;
    end else begin
      unique case (state)
        mwd_pkg::MWD_IDLE: begin
          first <= 1'b1;
          if (detect_mode) begin
            state <= mwd_pkg::MWD_WATCH;
          end
        end
        mwd_pkg::MWD_WATCH: begin
          if (sample.valid) begin
            first <= 1'b0;
          end
          if (!detect_mode) begin
            state <= mwd_pkg::MWD_IDLE;
          end
        end
        default: state <= mwd_pkg::MWD_IDLE;
      endcase
    end
  end

  genvar a;
  generate
    for (a = 0; a < 3; a++) begin : g_axis
      logic signed [mwd_pkg::SAMPLE_W:0] diff;
      logic [mwd_pkg::SAMPLE_W:0]        mag;
      logic [5:0] th;
      logic [5:0] need;
      logic       hit;
      assign th   = slots[(a + 1) * 6 +: 6];
      assign need = slots[(a + 5) * 6 +: 6];
      assign diff = ctrl_bits[1] ? (cur[a] - base[a]) : (cur[a] - prev[a]);
      assign mag  = diff[mwd_pkg::SAMPLE_W] ? (mwd_pkg::SAMPLE_W + 1)'(-diff) : diff;
      assign hit  = mag > {6'h00, th};

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          prev[a] <= '0;
          base[a] <= '0;
        end else if (state == mwd_pkg::MWD_WATCH && sample.valid) begin
          prev[a] <= cur[a];
          if (first) begin
            base[a] <= cur[a];
          end
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt[a]  <= 6'h00;
          flag[a] <= 1'b0;
        end else if (state != mwd_pkg::MWD_WATCH || !cfg[mwd_pkg::CFG_CNTEN_BIT]) begin
          cnt[a]  <= 6'h00;
          flag[a] <= 1'b0;
        end else if (sample.valid && !first) begin
          if (hit && !flag[a]) begin
            if (cnt[a] >= need) begin
              flag[a] <= 1'b1;
            end else begin
              cnt[a] <= cnt[a] + 6'h01;
            end
          end
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Combination
  // ****************************************************************
  logic [2:0] act;
  logic       wake_any;
  logic       wake_all;
  assign act      = ~pd;
  assign wake_any = |(flag & act);
  assign wake_all = (act != 3'b000) && ((flag & act) == act);

  // Status registered for the interrupt logic.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= '0;
    end else begin
      status.axis_flag <= flag;
      status.wake      <= ctrl_bits[0] ? wake_all : wake_any;
    end
  end

  // Status read value is assembled here and not from the slot memory.
  logic [31:0] rd_value;
  always_comb begin
    rd_value = 32'h0000_0000;
    unique case (rd_addr)
      mwd_pkg::ADDR_CONTROL: rd_value = {24'h000000, ctrl_bits, slot_rd};
      mwd_pkg::ADDR_CONFIG:  rd_value = {24'h000000, cfg};
      mwd_pkg::ADDR_POWER:   rd_value = {25'h0000000, pd, 4'h0};
      mwd_pkg::ADDR_STATUS:  rd_value = {28'h0000000, status.wake, status.axis_flag};
      default:               rd_value = 32'h0000_0000;
    endcase
  end

  // Read data register, loaded at the end of the wait state so it stands when ready is high.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (access && !pwrite && !rd_pend) begin
      prdata <= rd_value;
    end
  end

endmodule

`default_nettype wire

/* File: sim/mwd_detector_properties.sv */
`timescale 1ns/100ps
`default_nettype none

// ********
// Checker
// ********
module mwd_checker (
  // Clock and reset
  input wire logic                 pclk,
  input wire logic                 presetn,
  // APB slave
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [7:0]           paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  // Sensor side
  input wire logic                 detect_mode,
  input wire mwd_pkg::mwd_sample_s sample,
  input wire mwd_pkg::mwd_status_s status
);
  default clocking dcb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic rd_done;
  logic mapped;

  // Completed read, and decode of the four mapped words.
  assign rd_done = psel && penable && !pwrite && pready;
  assign mapped  = paddr inside {mwd_pkg::ADDR_CONTROL, mwd_pkg::ADDR_CONFIG,
                                 mwd_pkg::ADDR_POWER, mwd_pkg::ADDR_STATUS};

  // Bus timing: writes finish at once, reads wait exactly one cycle.
  a_write_no_wait: assert property (psel && penable && pwrite |-> pready)
    else $error("write access not answered at once");
  a_read_one_wait: assert property ($rose(penable) && psel && !pwrite |-> !pready ##1 pready)
    else $error("read access wait is not one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  a_err_reads_zero: assert property (rd_done && pslverr |-> prdata == 32'h0)
    else $error("unmapped read returned data");
  a_upper_bits_zero: assert property (rd_done |-> prdata[31:8] == 24'h0)
    else $error("read data above bit 7 not zero");
  a_mapped_no_err: assert property (psel && penable && pready && mapped |-> !pslverr)
    else $error("mapped access flagged as error");
  a_wake_needs_flag: assert property (status.wake |-> status.axis_flag != 3'h0)
    else $error("wake raised with no axis flag");
  a_idle_clears: assert property (!detect_mode ##1 !detect_mode ##1 !detect_mode ##1 !detect_mode |-> status == 4'h0)
    else $error("status not clear outside detection mode");
  a_flag_after_sample: assert property ($rose(|status.axis_flag) |->
      $past(sample.valid) || $past(sample.valid, 2) || $past(sample.valid, 3))
    else $error("axis flag rose without a sample");

  // Main scenarios reached.
  c_wake: cover property ($rose(status.wake));
  c_error: cover property (pslverr);
  c_read: cover property (rd_done);
endmodule

bind mwd_detector mwd_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .detect_mode, .sample, .status);

`default_nettype wire

/* File: sim/test_mwd_detector.sv */
`timescale 1ns/100ps
`default_nettype none

module test_mwd_detector;
  logic                 pclk = 1'h0;
  logic                 presetn = 1'h0;
  logic                 psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0]           paddr = 8'h00;
  logic [31:0]          pwdata = 32'h0, prdata, rv;
  logic                 pready, pslverr, re;
  logic                 detect_mode = 1'h0;
  mwd_pkg::mwd_sample_s smp = '0;
  mwd_pkg::mwd_status_s status, st;
  int                   mismatches = 0, checks_done = 0;
  // Slot rows: value written and value read back; slots 0 and 4 hold nothing.
  logic [5:0] wv [8] = '{6'h15, 6'h0A, 6'h1E, 6'h3F, 6'h2A, 6'h02, 6'h00, 6'h00};
  logic [5:0] ev [8] = '{6'h00, 6'h0A, 6'h1E, 6'h3F, 6'h00, 6'h02, 6'h00, 6'h00};

  mwd_detector u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .detect_mode, .sample(smp), .status);

  // A 100 ns clock.
  always #50 pclk = ~pclk;

  // About twenty times the expected run; a hang ends the run as a failure.
  initial begin
    #500000;
    mismatches++;
    give_verdict();
  end

  // Compare and count.
  task automatic chk(input string n, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  // One APB transfer, entered just after a rising edge; ready and data are taken at
  // the rising edge that ends the access, then the request is released.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rv = prdata;
    re = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, d);
    apb(1'h1, a, {24'h0, d});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    apb(1'h0, a, 32'h0);
    chk(n, rv, e);
  endtask

  // One sample pulse, then the status is captured once settled.
  task automatic samp(input int x, y, z);
    smp <= {1'h1, 11'(x), 11'(y), 11'(z)};
    @(posedge pclk);
    smp.valid <= 1'h0;
    repeat (4) @(negedge pclk);
    st = status;
    @(posedge pclk);
  endtask

  task automatic give_verdict();
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    rd(mwd_pkg::ADDR_CONTROL, 32'h0, "control reset");
    rd(mwd_pkg::ADDR_CONFIG, 32'h0, "config reset");
    rd(mwd_pkg::ADDR_POWER, 32'h0, "power reset");
    // All slots written first, so a shared slot would show on read-back.
    for (int i = 0; i < 8; i++) begin
      wr(mwd_pkg::ADDR_CONFIG, 8'(i));
      wr(mwd_pkg::ADDR_CONTROL, {2'h0, wv[i]});
    end
    for (int i = 0; i < 8; i++) begin
      wr(mwd_pkg::ADDR_CONFIG, 8'(i));
      rd(mwd_pkg::ADDR_CONTROL, {26'h0, ev[i]}, "slot");
    end
    apb(1'h0, 8'h7C, 32'h0);
    chk("unmapped data", rv, 32'h0);
    chk("unmapped error", {31'h0, re}, 32'h1);
    // OR mode: X needs three deltas of 20 over 10; Y sits exactly on 30.
    wr(mwd_pkg::ADDR_CONFIG, 8'h08);
    wr(mwd_pkg::ADDR_CONTROL, 8'h00);
    detect_mode <= 1'h1;
    @(posedge pclk);
    samp(0, 0, 0);
    samp(20, 30, 0);
    samp(0, 0, 0);
    chk("two events", st, 32'h0);
    samp(20, 30, 0);
    chk("or wake", st, 32'h9);
    rd(mwd_pkg::ADDR_STATUS, 32'h9, "status word");
    // AND mode: X alone is not enough until Y and Z are powered down.
    wr(mwd_pkg::ADDR_CONTROL, 8'h40);
    samp(0, 0, 0);
    chk("and partial", st, 32'h1);
    wr(mwd_pkg::ADDR_POWER, 8'h60);
    samp(20, 0, 0);
    chk("and masked", st, 32'h9);
    wr(mwd_pkg::ADDR_CONFIG, 8'h00);
    samp(0, 0, 0);
    chk("count off", st, 32'h0);
    // Slow ramp 0, 8, 16: deltas of 8 stay quiet, 16 from baseline fires.
    detect_mode <= 1'h0;
    wr(mwd_pkg::ADDR_POWER, 8'h00);
    wr(mwd_pkg::ADDR_CONFIG, 8'h0D);
    wr(mwd_pkg::ADDR_CONTROL, 8'h00);
    detect_mode <= 1'h1;
    @(posedge pclk);
    samp(0, 0, 0);
    samp(8, 0, 0);
    samp(16, 0, 0);
    chk("previous delta", st, 32'h0);
    detect_mode <= 1'h0;
    wr(mwd_pkg::ADDR_CONTROL, 8'h80);
    detect_mode <= 1'h1;
    @(posedge pclk);
    samp(0, 0, 0);
    samp(8, 0, 0);
    chk("baseline small", st, 32'h0);
    samp(16, 0, 0);
    chk("baseline delta", st, 32'h9);
    give_verdict();
  end
endmodule

`default_nettype wire
